/* File: design/vbp_pkg.sv */
package vbp_pkg;

    // -------------------------------------------------------------------
    // position and timing constants
    // -------------------------------------------------------------------
    localparam int          NIB_W          = 4;
    localparam int          LF_CNT_W       = 5;
    localparam logic [4:0]  LF_STEPS       = 5'h13;  // 19 steps per burst
    localparam logic [4:0]  LF_ONE         = 5'h01;
    localparam logic [4:0]  LF_ZERO        = 5'h00;
    localparam real         REF_CLK_MHZ    = 100.0;
    localparam real         STEP_CLK_MHZ   = 2.0;
    localparam int          STEP_DIV       = int'(REF_CLK_MHZ / STEP_CLK_MHZ);
    localparam int          DIV_W          = 6;
    localparam logic [5:0]  DIV_LAST       = 6'(STEP_DIV - 1);
    localparam logic [5:0]  DIV_ZERO       = 6'h00;
    localparam logic [5:0]  DIV_ONE        = 6'h01;
    localparam logic [3:0]  NIB_ZERO       = 4'h0;
    localparam logic [3:0]  NIB_ONE        = 4'h1;
    localparam logic [3:0]  NIB_MAX        = 4'hF;
    // reset presets of the active-high counter bits (lines are inverted)
    localparam logic [3:0]  LO_NIB_HORIZ   = 4'h4;   // lines 1,2,8 high, 4 low
    localparam logic [3:0]  LO_NIB_VERT    = 4'hF;   // lines 1,2,8 low, 4 low as always
    localparam logic [3:0]  HI_NIB_HORIZ   = 4'h0;   // weight 256 line high
    localparam logic [3:0]  HI_NIB_VERT    = 4'hF;   // weight 32..256 lines low

    // -------------------------------------------------------------------
    // position carrier
    // -------------------------------------------------------------------
    typedef struct packed {
        logic       hi_fifth;   // weight 512
        logic [3:0] hi_nib;     // weights 32..256
        logic       lo_fifth;   // weight 16
        logic [3:0] lo_nib;     // weights 1..8
    } vbp_pos_type;

    typedef struct packed {
        logic       line_feed;
        logic       end_of_line_signal;
        logic       vertical_cursor_pulse;
        logic       double_size_cmd;
    } vbp_lf_req_type;

    typedef enum logic [1:0] {
        LF_IDLE   = 2'b00,
        LF_RUN    = 2'b01,
        LF_SECOND = 2'b10
    } vbp_lf_state_type;

endpackage

/* File: design/vbp_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module vbp_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,   // system clock
    input  wire logic         rst_n_i,     // async reset, active low
    input  wire logic         ce_i,        // clock enable
    input  wire logic [W-1:0] d_i,         // asynchronous inputs
    input  wire logic [W-1:0] rst_val_i,   // idle level (constant at instance)
    output logic      [W-1:0] q_o          // synchronised outputs
);
    logic [W-1:0] meta;
    logic [W-1:0] held;

    // flops keep the input relative to its idle level, so reset shows the
    // idle level and no false request or edge follows the release
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            held <= '0;
        end else if (ce_i) begin
            meta <= d_i ^ rst_val_i;
            held <= meta;
        end
    end
    assign q_o = held ^ rst_val_i;
endmodule
`default_nettype wire

/* File: design/vbp_counter.sv */
// Summary of operation
// - horizontal reset loads low nibble so lines 1,2,8 high, line 4 low.
// - horizontal reset clears low fifth bit; weight-16 line high.
// - vertical reset drives weight 1,2,8 lines low.
// - vertical reset presets low fifth bit; weight-16 line low.
// - horizontal reset keeps weight-256 bit clear; its line high.
// - vertical reset drives weight 32 to 512 lines low.
// - home, alpha origin or page-full pulse resets both halves.
// - second graphics signal blocks alpha origin and page-full detection.
// - one byte enable per load; bits one to four enter selected nibble.
// - data bit five presets the selected half's fifth bit.
// - count down while aux and plot up inputs are high and no cursor raise is forced.
// - any low direction input makes steps count up.
// - each low step pulse moves low nibble one count.
// - borrow toggles bit 16; high nibble decrements if bit was clear.
// - carry toggles bit 16; high nibble increments on alternate carries.
// - line feed, strapped end of line, cursor pulse or double size start burst.
// - line-feed enable sets on a 2 MHz edge only without page full.
// - enable passes 2 MHz steps; clears after 19, or 38 for double-size line feed or end of line.
// - double flag overrides first terminal count and is cleared by it.
// - keyboard cursor raise forces up count until burst end plus one tick.
`timescale 1ns/10ps
`default_nettype none
module vbp_counter
    import vbp_pkg::*;
(
    input  wire logic        ref_clk_i,                // 100 MHz clock
    input  wire logic        rst_n_i,                  // async reset, active low
    input  wire logic        ce_i,                     // clock enable
    input  wire logic        vertical_tube_i,          // 1: vertical tube format
    input  wire logic        automatic_newline_strap_i,// end of line also feeds
    input  wire logic        home_n_i,                 // return to origin, low
    input  wire logic        alpha_origin_request_n_i, // alpha origin, low
    input  wire logic        full_page_pulse_n_i,      // looped page-full pulse, low
    input  wire logic        graphics_mode_second_i,   // graphics byte loading
    input  wire logic [4:0]  data_in_i,                // data bits 1..5
    input  wire logic        low_byte_load_enable_i,   // load low half, high pulse
    input  wire logic        high_byte_load_enable_i,  // load high half, high pulse
    input  wire logic        aux_up_n_i,               // aux up request, low
    input  wire logic        plot_up_n_i,              // plot up request, low
    input  wire logic        cursor_raise_request_n_i, // keyboard cursor up, low
    input  wire logic [2:0]  step_n_i,                 // step pulses, low
    input  wire logic        line_feed_i,              // line feed command
    input  wire logic        end_of_line_signal_n_i,   // end of line, low
    input  wire logic        vertical_cursor_pulse_i,  // vertical cursor pulse
    input  wire logic        double_size_char_n_i,     // double size mode, low
    input  wire logic        page_full_i,              // page full condition
    output vbp_pos_type      pos_n_o,                  // active-low weight lines
    output logic             low_half_fifth_bit_line_n_o,  // weight 16 line, low
    output logic             high_half_fifth_bit_line_n_o, // weight 512 line, low
    output logic             weight_256_line_n_o,      // weight 256 line, low
    output logic             lf_enable_o,              // line-feed clock enable
    output logic             count_up_o,               // current direction
    output logic             page_full_detect_en_o     // page-full detection enable
);
    // -------------------------------------------------------------------
    // input synchronisation
    // -------------------------------------------------------------------
    localparam int SW = 18;
    logic [SW-1:0] raw_in;
    logic [SW-1:0] idle_in;
    logic [SW-1:0] s_in;

    assign raw_in  = {home_n_i, alpha_origin_request_n_i, full_page_pulse_n_i,
                      graphics_mode_second_i, low_byte_load_enable_i,
                      high_byte_load_enable_i, aux_up_n_i, plot_up_n_i,
                      cursor_raise_request_n_i, step_n_i, line_feed_i,
                      end_of_line_signal_n_i, vertical_cursor_pulse_i,
                      double_size_char_n_i, page_full_i, data_in_i[4]};
    assign idle_in = {3'b111, 3'b000, 3'b111, 3'b111, 1'b0, 1'b1, 1'b0,
                      1'b1, 1'b0, 1'b0};

    vbp_sync #(.W(SW)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .d_i       (raw_in),
        .rst_val_i (idle_in),
        .q_o       (s_in)
    );

    logic [3:0] s_data;
    logic [3:0] d1;
    logic [3:0] d2;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            d1 <= NIB_ZERO;
            d2 <= NIB_ZERO;
        end else if (ce_i) begin
            d1 <= data_in_i[3:0];
            d2 <= d1;
        end
    end
    assign s_data = d2;

    wire s_home_n  = s_in[17];
    wire s_alpha_n = s_in[16];
    wire s_pf_n    = s_in[15];
    wire s_graf2   = s_in[14];
    wire s_lo_en   = s_in[13];
    wire s_hi_en   = s_in[12];
    wire s_aux_n   = s_in[11];
    wire s_plot_n  = s_in[10];
    wire s_cur_n   = s_in[9];
    wire [2:0] s_step_n = s_in[8:6];
    wire s_lf      = s_in[5];
    wire s_eol_n   = s_in[4];
    wire s_ycur    = s_in[3];
    wire s_dbl_n   = s_in[2];
    wire s_full    = s_in[1];
    wire s_d5      = s_in[0];

    // -------------------------------------------------------------------
    // 2 MHz tick
    // -------------------------------------------------------------------
    logic [DIV_W-1:0] div;
    wire              tick = (div == DIV_LAST);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div <= DIV_ZERO;
        end else if (ce_i) begin
            div <= tick ? DIV_ZERO : div + DIV_ONE;
        end
    end

    // -------------------------------------------------------------------
    // edge detection of strobes
    // -------------------------------------------------------------------
    logic [2:0] step_q;
    logic       lo_q;
    logic       hi_q;
    logic       lf_q;
    logic       eol_q;
    logic       ycur_q;
    logic       cur_q;
    logic       dbl_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_q <= 3'b111;
            lo_q   <= 1'b0;
            hi_q   <= 1'b0;
            lf_q   <= 1'b0;
            eol_q  <= 1'b1;
            ycur_q <= 1'b0;
            cur_q  <= 1'b1;
            dbl_q  <= 1'b1;
        end else if (ce_i) begin
            step_q <= s_step_n;
            lo_q   <= s_lo_en;
            hi_q   <= s_hi_en;
            lf_q   <= s_lf;
            eol_q  <= s_eol_n;
            ycur_q <= s_ycur;
            cur_q  <= s_cur_n;
            dbl_q  <= s_dbl_n;
        end
    end

    wire [2:0] step_fall = step_q & ~s_step_n;
    wire       lo_load   = s_lo_en & ~lo_q & s_graf2;
    wire       hi_load   = s_hi_en & ~hi_q & s_graf2 & ~lo_load;
    wire       lf_rise   = s_lf & ~lf_q;
    wire       eol_fall  = eol_q & ~s_eol_n & automatic_newline_strap_i;
    wire       ycur_rise = s_ycur & ~ycur_q;
    wire       cur_fall  = cur_q & ~s_cur_n;
    wire       dbl       = ~s_dbl_n;
    wire       dbl_fall  = dbl_q & ~s_dbl_n;

    // -------------------------------------------------------------------
    // reset request and presets
    // -------------------------------------------------------------------
    wire alpha_ok  = ~s_alpha_n & ~s_graf2;
    wire pos_reset = ~s_home_n | alpha_ok | ~s_pf_n;
    wire [3:0] lo_preset = vertical_tube_i ? LO_NIB_VERT : LO_NIB_HORIZ;
    wire       lo5_preset = vertical_tube_i;
    wire [3:0] hi_preset = vertical_tube_i ? HI_NIB_VERT : HI_NIB_HORIZ;
    wire       hi5_preset = vertical_tube_i;

    // -------------------------------------------------------------------
    // direction and cursor raise latch
    // -------------------------------------------------------------------
    logic cursor_raise_request_force;
    logic burst_done;
    logic release_pend;
    wire  dir_up = ~s_aux_n | ~s_plot_n | cursor_raise_request_force;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cursor_raise_request_force <= 1'b0;
            release_pend <= 1'b0;
        end else if (ce_i) begin
            if (cur_fall) begin
                cursor_raise_request_force <= 1'b1;
                release_pend <= 1'b0;
            end else if (burst_done && cursor_raise_request_force) begin
                release_pend <= 1'b1;
            end else if (release_pend && tick) begin
                cursor_raise_request_force <= 1'b0;
                release_pend <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // line feed burst
    // -------------------------------------------------------------------
    vbp_lf_state_type lf_state;
    logic             start_pend;
    logic             dbl_flag;
    logic [LF_CNT_W-1:0] lf_cnt;
    wire lf_start  = lf_rise | eol_fall | ycur_rise | dbl_fall;
    wire dbl_req   = dbl & (lf_rise | eol_fall);
    wire lf_step   = (lf_state != LF_IDLE) & tick;
    wire lf_term   = lf_step & (lf_cnt == LF_ONE);
    assign burst_done = lf_term & ~dbl_flag;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lf_state   <= LF_IDLE;
            start_pend <= 1'b0;
            dbl_flag   <= 1'b0;
            lf_cnt     <= LF_ZERO;
        end else if (ce_i) begin
            if (lf_start) begin
                start_pend <= 1'b1;
            end else if (tick && !s_full) begin
                start_pend <= 1'b0;
            end
            if (dbl_req) begin
                dbl_flag <= 1'b1;
            end else if (lf_term) begin
                dbl_flag <= 1'b0;
            end
            case (lf_state)
                LF_IDLE: begin
                    if ((start_pend || lf_start) && tick && !s_full) begin
                        lf_state <= LF_RUN;
                        lf_cnt   <= LF_STEPS;
                    end
                end
                LF_RUN, LF_SECOND: begin
                    if (lf_step) begin
                        if (lf_term && (dbl_flag || dbl_req)) begin
                            lf_state <= LF_SECOND;
                            lf_cnt   <= LF_STEPS;
                        end else if (lf_term) begin
                            lf_state <= LF_IDLE;
                            lf_cnt   <= LF_ZERO;
                        end else begin
                            lf_cnt <= lf_cnt - LF_ONE;
                        end
                    end
                end
                default: begin
                    lf_state <= LF_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // position counter
    // -------------------------------------------------------------------
    vbp_pos_type pos;
    vbp_pos_type next_pos;
    wire step      = (|step_fall) | lf_step;
    wire borrow    = step & ~dir_up & (pos.lo_nib == NIB_ZERO);
    wire carry     = step & dir_up & (pos.lo_nib == NIB_MAX);
    wire hi_dec    = borrow & ~pos.lo_fifth;
    wire hi_inc    = carry & pos.lo_fifth;

    always_comb begin
        next_pos = pos;
        if (pos_reset) begin
            next_pos = '{hi_fifth: hi5_preset, hi_nib: hi_preset,
                         lo_fifth: lo5_preset, lo_nib: lo_preset};
        end else if (lo_load) begin
            next_pos.lo_nib = s_data;
            next_pos.lo_fifth = s_d5 ? 1'b1 : pos.lo_fifth;
        end else if (hi_load) begin
            next_pos.hi_nib = s_data;
            next_pos.hi_fifth = s_d5 ? 1'b1 : pos.hi_fifth;
        end else if (step) begin
            next_pos.lo_nib = dir_up ? pos.lo_nib + NIB_ONE : pos.lo_nib - NIB_ONE;
            if (borrow || carry) begin
                next_pos.lo_fifth = ~pos.lo_fifth;
            end
            if (hi_dec) begin
                next_pos.hi_nib = pos.hi_nib - NIB_ONE;
            end else if (hi_inc) begin
                next_pos.hi_nib = pos.hi_nib + NIB_ONE;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos <= '0;
        end else if (ce_i) begin
            pos <= next_pos;
        end
    end

    // -------------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_n_o                      <= '1;
            low_half_fifth_bit_line_n_o  <= 1'b1;
            high_half_fifth_bit_line_n_o <= 1'b1;
            weight_256_line_n_o          <= 1'b1;
            lf_enable_o                  <= 1'b0;
            count_up_o                   <= 1'b0;
            page_full_detect_en_o        <= 1'b0;
        end else if (ce_i) begin
            pos_n_o                      <= ~next_pos;
            low_half_fifth_bit_line_n_o  <= ~next_pos.lo_fifth;
            high_half_fifth_bit_line_n_o <= ~next_pos.hi_fifth;
            weight_256_line_n_o          <= ~next_pos.hi_nib[3];
            lf_enable_o                  <= (lf_state != LF_IDLE);
            count_up_o                   <= dir_up;
            page_full_detect_en_o        <= ~s_graf2;
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    a_reset_vert_preset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && pos_reset && vertical_tube_i |=> pos.lo_nib == LO_NIB_VERT && pos.lo_fifth)
        else $error("vertical reset preset wrong");
    a_reset_horiz_preset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && pos_reset && !vertical_tube_i
        |=> pos.lo_nib == LO_NIB_HORIZ && !pos.lo_fifth && pos.hi_nib == HI_NIB_HORIZ)
        else $error("horizontal reset preset wrong");
    a_reset_hi_vert: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && pos_reset && vertical_tube_i |=> pos.hi_nib == HI_NIB_VERT && pos.hi_fifth)
        else $error("vertical high preset wrong");
    a_graf_blocks_alpha: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && s_graf2 && s_home_n && s_pf_n && !lo_load && !hi_load && !step
        |=> pos == $past(pos))
        else $error("alpha origin taken in graphics");
    a_down_step_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && step && !dir_up && !pos_reset && !lo_load && !hi_load
        |=> pos.lo_nib == $past(pos.lo_nib) - NIB_ONE)
        else $error("down step not one count");
    a_borrow_toggle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && borrow && !pos_reset && !lo_load && !hi_load
        |=> pos.lo_fifth != $past(pos.lo_fifth))
        else $error("borrow did not toggle bit 16");
    a_carry_high_inc: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && hi_inc && !pos_reset && !lo_load && !hi_load
        |=> pos.hi_nib == $past(pos.hi_nib) + NIB_ONE)
        else $error("carry did not raise high half");
    a_lf_no_full_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && lf_state == LF_IDLE && s_full |=> lf_state == LF_IDLE)
        else $error("burst started during page full");
    a_lf_count_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        lf_state != LF_IDLE |-> lf_cnt <= LF_STEPS && lf_cnt != LF_ZERO)
        else $error("burst counter out of range");
endmodule
`default_nettype wire

/* File: tb/vbp_term_model.sv */
`timescale 1ns/10ps
`default_nettype none
module vbp_term_model (
    input  wire logic       ref_clk_i, // bench clock
    output logic      [4:0] data_o,    // data bits 1..5
    output logic            lo_en_o,   // low byte load enable
    output logic            hi_en_o,   // high byte load enable
    output logic      [2:0] step_n_o   // step pulses, low
);
    // ----
    // graphics byte loads and step pulses
    // ----
    initial begin
        {data_o, lo_en_o, hi_en_o, step_n_o} = 10'h007;
    end
    // data has no handshake, so it is settled well before the strobe
    task automatic load(input logic hi, input logic [4:0] d);
        @(posedge ref_clk_i);
        #1;
        data_o = d;
        repeat (4) @(posedge ref_clk_i);
        #1;
        if (hi) hi_en_o = 1'b1;
        else lo_en_o = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        {lo_en_o, hi_en_o} = 2'h0;
        repeat (8) @(posedge ref_clk_i);
        #1;
    endtask
    // pulse kept 4 clocks so the synchroniser cannot miss it
    task automatic step(input int k);
        repeat (4) @(posedge ref_clk_i);
        #1;
        step_n_o[k] = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        step_n_o[k] = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
    import vbp_pkg::*;
    logic ref_clk_i, rst_n_i, ce_i, vertical_tube_i, automatic_newline_strap_i;
    logic home_n_i, alpha_origin_request_n_i, full_page_pulse_n_i, graphics_mode_second_i;
    logic aux_up_n_i, plot_up_n_i, cursor_raise_request_n_i, line_feed_i, page_full_i;
    logic end_of_line_signal_n_i, vertical_cursor_pulse_i, double_size_char_n_i;
    logic [4:0] data_in_i;
    logic [2:0] step_n_i;
    logic low_byte_load_enable_i, high_byte_load_enable_i, lf_enable_o, count_up_o;
    logic low_half_fifth_bit_line_n_o, high_half_fifth_bit_line_n_o, weight_256_line_n_o;
    logic page_full_detect_en_o;
    vbp_pos_type pos_n_o;
    logic [9:0] e;
    int n_mismatch = 0;
    int num_checks = 0;
    int k;
    vbp_counter i_dut (.*);
    vbp_term_model i_term (
        .ref_clk_i (ref_clk_i),
        .data_o    (data_in_i),
        .lo_en_o   (low_byte_load_enable_i),
        .hi_en_o   (high_byte_load_enable_i),
        .step_n_o  (step_n_i)
    );
    // ----
    // helpers
    // ----
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk_pos(input logic [9:0] v);
        `CHK(pos_n_o, vbp_pos_type'(~v))
    endtask
    task automatic pulse(ref logic s);
        s = ~s;
        tick(4);
        s = ~s;
        tick(8);
    endtask
    // waits are bounded so a burst that never starts still ends the check
    task automatic burst(input int d);
        for (int i = 0; i < 300 && lf_enable_o !== 1'b1; i++) tick(1);
        for (int i = 0; i < 2500 && lf_enable_o !== 1'b0; i++) tick(1);
        tick(8);
        e = e + 10'(d);
        chk_pos(e);
    endtask
    task automatic results();
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        results();
    end
    // ----
    // tests
    // ----
    initial begin
        {line_feed_i, vertical_cursor_pulse_i, page_full_i, graphics_mode_second_i} = 4'h0;
        {vertical_tube_i, rst_n_i, ce_i, automatic_newline_strap_i} = 4'h3;
        {home_n_i, alpha_origin_request_n_i, full_page_pulse_n_i, aux_up_n_i} = 4'hF;
        {plot_up_n_i, cursor_raise_request_n_i, end_of_line_signal_n_i} = 3'h7;
        double_size_char_n_i = 1'b1;
        tick(8);
        rst_n_i = 1'b1;
        tick(4);
        pulse(home_n_i);
        chk_pos(10'h004);
        `CHK(low_half_fifth_bit_line_n_o, 1'b1)
        `CHK(weight_256_line_n_o, 1'b1)
        graphics_mode_second_i = 1'b1;
        i_term.load(1'b0, 5'h13);
        chk_pos(10'h013);
        i_term.load(1'b1, 5'h15);
        chk_pos(10'h2B3);
        pulse(alpha_origin_request_n_i);
        chk_pos(10'h2B3);
        `CHK(page_full_detect_en_o, 1'b0)
        graphics_mode_second_i = 1'b0;
        pulse(alpha_origin_request_n_i);
        chk_pos(10'h004);
        `CHK(page_full_detect_en_o, 1'b1)
        vertical_tube_i = 1'b1;
        pulse(home_n_i);
        e = 10'h3FF;
        chk_pos(e);
        `CHK(low_half_fifth_bit_line_n_o, 1'b0)
        `CHK(high_half_fifth_bit_line_n_o, 1'b0)
        i_term.step(0);
        chk_pos(10'h3FE);
        pulse(full_page_pulse_n_i);
        chk_pos(e);
        for (k = 0; k < 32; k++) begin
            i_term.step(k % 3);
            if (k == 15) chk_pos(10'h3EF);
        end
        chk_pos(10'h3DF);
        aux_up_n_i = 1'b0;
        i_term.step(1);
        chk_pos(10'h3E0);
        `CHK(count_up_o, 1'b1)
        {aux_up_n_i, plot_up_n_i} = 2'b10;
        i_term.step(2);
        chk_pos(10'h3E1);
        plot_up_n_i = 1'b1;
        i_term.step(0);
        e = 10'h3E0;
        chk_pos(e);
        pulse(line_feed_i);
        burst(-19);
        pulse(vertical_cursor_pulse_i);
        burst(-19);
        pulse(end_of_line_signal_n_i);
        burst(-19);
        double_size_char_n_i = 1'b0;
        burst(-19);
        pulse(line_feed_i);
        burst(-38);
        double_size_char_n_i = 1'b1;
        page_full_i = 1'b1;
        pulse(line_feed_i);
        tick(150);
        `CHK(lf_enable_o, 1'b0)
        page_full_i = 1'b0;
        burst(-19);
        {cursor_raise_request_n_i, vertical_cursor_pulse_i} = 2'b01;
        tick(4);
        {cursor_raise_request_n_i, vertical_cursor_pulse_i} = 2'b10;
        burst(19);
        tick(60);
        `CHK(count_up_o, 1'b0)
        automatic_newline_strap_i = 1'b0;
        pulse(end_of_line_signal_n_i);
        tick(100);
        `CHK(lf_enable_o, 1'b0)
        chk_pos(e);
        results();
    end
endmodule
`default_nettype wire
